// [core/ictc_pkg.sv]
// package: constants and types for the isa cycle timing configuration block
// Contract
// - each cycle type has its own two-bit delay; codes give 0 to 3 bus clocks.
// - delay code 00 asserts command at the falling edge of address latch.
// - i/o cycle delay comes from command-delay bits 1:0, default one.
// - 8-bit memory delay comes from command-delay bits 3:2, default one.
// - 16-bit memory delay comes from command-delay bits 5:4, default zero.
// - 8-bit wait states from wait register bits 3:2: five down to two.
// - wait register bit 7 adds one bus clock of address hold.
package ictc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CMD_DELAY = 8'h05;
  localparam logic [7:0] IDX_WAIT_HOLD = 8'h10;
  localparam logic [7:0] ADDR_CMD_DELAY = {IDX_CMD_DELAY[5:0], 2'b00};
  localparam logic [7:0] ADDR_WAIT_HOLD = {IDX_WAIT_HOLD[5:0], 2'b00};
  localparam logic [7:0] RST_CMD_DELAY = 8'h05;
  localparam logic [7:0] RST_WAIT_HOLD = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int IO_DLY_LSB = 0;
  localparam int BYTE_DLY_LSB = 2;
  localparam int WORD_DLY_LSB = 4;
  localparam int BYTE_WAIT_LSB = 2;
  localparam int WORD_WAIT_LSB = 4;
  localparam int ADDR_HOLD_BIT = 7;

  // ----------------------------------------------------------------
  // wait-state bases: code 00 gives the base, each step one fewer
  // ----------------------------------------------------------------
  localparam logic [2:0] BYTE_WAIT_BASE = 3'h5;
  localparam logic [2:0] WORD_WAIT_BASE = 3'h3;

  // ----------------------------------------------------------------
  // bus clock timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_PS = 5000;
  localparam int BCLK_PERIOD_PS = 125000;
  localparam int BCLK_CYC = BCLK_PERIOD_PS / SYS_PERIOD_PS;
  localparam logic [4:0] BCLK_LAST = 5'(BCLK_CYC - 1);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ICTC_IO = 2'h0,
    ICTC_MEM8 = 2'h1,
    ICTC_MEM16 = 2'h2
  } ictc_type_t;

  typedef enum logic [4:0] {
    ICTC_IDLE = 5'h01,
    ICTC_ALE = 5'h02,
    ICTC_DLY = 5'h04,
    ICTC_CMD = 5'h08,
    ICTC_HOLD = 5'h10
  } ictc_state_t;

  typedef struct packed {
    logic [7:0] cmd_delay;
    logic [7:0] wait_hold;
  } ictc_cfg_t;

  // delay field of the selected cycle type
  function automatic logic [1:0] ictc_delay(ictc_cfg_t cfg, ictc_type_t t);
    logic [1:0] d;
    d = cfg.cmd_delay[IO_DLY_LSB +: 2];
    if (t == ICTC_MEM8)
      d = cfg.cmd_delay[BYTE_DLY_LSB +: 2];
    else if (t == ICTC_MEM16)
      d = cfg.cmd_delay[WORD_DLY_LSB +: 2];
    return d;
  endfunction

  // wait-state count; i/o cycles are 8-bit cycles on the bus
  function automatic logic [2:0] ictc_waits(ictc_cfg_t cfg, ictc_type_t t);
    logic [2:0] w;
    if (t == ICTC_MEM16)
      w = WORD_WAIT_BASE - {1'b0, cfg.wait_hold[WORD_WAIT_LSB +: 2]};
    else
      w = BYTE_WAIT_BASE - {1'b0, cfg.wait_hold[BYTE_WAIT_LSB +: 2]};
    return w;
  endfunction

endpackage

// [core/ictc_regs.sv]
// configuration register pair with registered read data
`timescale 1ns/1ps
`default_nettype none
module ictc_regs
  import ictc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wr_cmd,
  input wire logic wr_wait,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  input wire logic rd_cmd,
  input wire logic rd_wait,
  output ictc_cfg_t cfg,
  output logic [7:0] rd_data
);

  ictc_cfg_t next_cfg;
  logic [7:0] next_rd_data;

  always_comb
  begin
    next_cfg = cfg;
    next_rd_data = rd_data;
    // reserved bits are stored as written; timing never looks at them
    if (wr_cmd)
      next_cfg.cmd_delay = wr_data;
    if (wr_wait)
      next_cfg.wait_hold = wr_data;
    if (rd_en)
      next_rd_data = rd_cmd ? cfg.cmd_delay :
                     rd_wait ? cfg.wait_hold : 8'h00;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg <= '{cmd_delay: RST_CMD_DELAY, wait_hold: RST_WAIT_HOLD};
      rd_data <= 8'h00;
    end
    else
    begin
      cfg <= next_cfg;
      rd_data <= next_rd_data;
    end
  end

endmodule // ictc_regs
`default_nettype wire

// [core/ictc_top.sv]
// isa cycle timing: axi4-lite configuration slave and cycle timer
`timescale 1ns/1ps
`default_nettype none
module ictc_top
  import ictc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cyc_req,
  input wire ictc_type_t cyc_type,
  output logic cyc_busy,
  output logic cyc_done,
  output logic isa_ale,
  output logic isa_cmd_n,
  output logic isa_addr_valid
);

  // ----------------------------------------------------------------
  // register bus slave
  // ----------------------------------------------------------------
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [7:0] w_byte, next_w_byte;
  logic w_lane0, next_w_lane0;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic do_write, wr_cmd, wr_wait, ar_hs, rd_cmd, rd_wait;
  logic [7:0] rd_byte;
  ictc_cfg_t cfg;

  assign s_axi_rdata = {24'h000000, rd_byte};

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    // one write at a time: the response must drain first
    do_write = aw_held && w_held && !s_axi_bvalid;
    wr_cmd = do_write && w_lane0 && (aw_addr == ADDR_CMD_DELAY);
    wr_wait = do_write && w_lane0 && (aw_addr == ADDR_WAIT_HOLD);
    next_bresp = s_axi_bresp;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bresp = (aw_addr == ADDR_CMD_DELAY ||
                    aw_addr == ADDR_WAIT_HOLD) ? RESP_OKAY : RESP_SLVERR;
    end
    next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
    next_awready = !next_aw_held;
    next_wready = !next_w_held;

    ar_hs = s_axi_arvalid && s_axi_arready;
    rd_cmd = s_axi_araddr == ADDR_CMD_DELAY;
    rd_wait = s_axi_araddr == ADDR_WAIT_HOLD;
    next_rresp = s_axi_rresp;
    if (ar_hs)
      next_rresp = (rd_cmd || rd_wait) ? RESP_OKAY : RESP_SLVERR;
    next_rvalid = ar_hs || (s_axi_rvalid && !s_axi_rready);
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
    end
  end

  ictc_regs u_regs (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .wr_cmd(wr_cmd),
    .wr_wait(wr_wait),
    .wr_data(w_byte),
    .rd_en(ar_hs),
    .rd_cmd(rd_cmd),
    .rd_wait(rd_wait),
    .cfg(cfg),
    .rd_data(rd_byte)
  );

  // ----------------------------------------------------------------
  // bus clock tick
  // ----------------------------------------------------------------
  logic [4:0] div, next_div;
  logic tick;

  always_comb
  begin
    tick = div == BCLK_LAST;
    next_div = tick ? 5'h00 : div + 5'h01;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      div <= 5'h00;
    else
      div <= next_div;
  end

  // ----------------------------------------------------------------
  // cycle timer
  // ----------------------------------------------------------------
  // settings are sampled when a cycle starts, so a write mid-cycle
  // cannot stretch or cut the strobe already in flight
  ictc_state_t state, next_state;
  ictc_type_t cur_type, next_type;
  logic [2:0] cnt, next_cnt;
  logic [1:0] dly, next_dly_q, dly_q;
  logic [2:0] waits, next_waits, waits_q;
  logic hold_q, next_hold;
  logic next_done;

  always_comb
  begin
    dly = ictc_delay(cfg, cyc_type);
    waits = ictc_waits(cfg, cyc_type);
    next_state = state;
    next_type = cur_type;
    next_cnt = cnt;
    next_dly_q = dly_q;
    next_waits = waits_q;
    next_hold = hold_q;
    next_done = 1'b0;
    unique case (state)
      ICTC_IDLE:
        if (cyc_req)
        begin
          next_state = ICTC_ALE;
          next_type = cyc_type;
          next_dly_q = dly;
          next_waits = waits;
          next_hold = cfg.wait_hold[ADDR_HOLD_BIT];
        end
      ICTC_ALE:
        if (tick)
        begin
          if (dly_q == 2'h0)
          begin
            next_state = ICTC_CMD;
            next_cnt = waits_q;
          end
          else
          begin
            next_state = ICTC_DLY;
            next_cnt = {1'b0, dly_q - 2'h1};
          end
        end
      ICTC_DLY:
        if (tick)
        begin
          if (cnt == 3'h0)
          begin
            next_state = ICTC_CMD;
            next_cnt = waits_q;
          end
          else
            next_cnt = cnt - 3'h1;
        end
      ICTC_CMD:
        if (tick)
        begin
          if (cnt != 3'h0)
            next_cnt = cnt - 3'h1;
          else if (hold_q)
            next_state = ICTC_HOLD;
          else
          begin
            next_state = ICTC_IDLE;
            next_done = 1'b1;
          end
        end
      ICTC_HOLD:
        if (tick)
        begin
          next_state = ICTC_IDLE;
          next_done = 1'b1;
        end
      default:
        next_state = ICTC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= ICTC_IDLE;
      cur_type <= ICTC_IO;
      cnt <= 3'h0;
      dly_q <= 2'h0;
      waits_q <= 3'h0;
      hold_q <= 1'b0;
      cyc_done <= 1'b0;
      cyc_busy <= 1'b0;
      isa_ale <= 1'b0;
      isa_cmd_n <= 1'b1;
      isa_addr_valid <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cur_type <= next_type;
      cnt <= next_cnt;
      dly_q <= next_dly_q;
      waits_q <= next_waits;
      hold_q <= next_hold;
      cyc_done <= next_done;
      cyc_busy <= next_state != ICTC_IDLE;
      isa_ale <= next_state == ICTC_ALE;
      isa_cmd_n <= next_state != ICTC_CMD;
      isa_addr_valid <= next_state != ICTC_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence ale_ends;
    state == ICTC_ALE && tick;
  endsequence

  sequence cmd_ends;
    state == ICTC_CMD && tick && cnt == 3'h0;
  endsequence

  chk_delay_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ale_ends and (dly_q != 2'h0) |=> state == ICTC_DLY && cnt == dly_q - 2'h1)
    else $error("delay count does not match code");
  chk_zero_delay: assert property (@(posedge clk_sys) disable iff (sys_rst)
    ale_ends and (dly_q == 2'h0) |=> $fell(isa_ale) && $fell(isa_cmd_n))
    else $error("zero delay did not start command at ale fall");
  chk_io_field: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == ICTC_IDLE && cyc_req && cyc_type == ICTC_IO
    |=> dly_q == $past(cfg.cmd_delay[1:0]))
    else $error("i/o delay not from bits 1:0");
  chk_byte_field: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == ICTC_IDLE && cyc_req && cyc_type == ICTC_MEM8
    |=> dly_q == $past(cfg.cmd_delay[3:2]))
    else $error("8-bit memory delay not from bits 3:2");
  chk_word_field: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state == ICTC_IDLE && cyc_req && cyc_type == ICTC_MEM16
    |=> dly_q == $past(cfg.cmd_delay[5:4]))
    else $error("16-bit memory delay not from bits 5:4");
  chk_byte_waits: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(state == ICTC_CMD) && cur_type != ICTC_MEM16
    |-> cnt == 3'h5 - {1'b0, cfg.wait_hold[3:2]} || $past(wr_wait, 2))
    else $error("8-bit wait count wrong");
  chk_word_waits: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(state == ICTC_CMD) && cur_type == ICTC_MEM16
    |-> cnt == 3'h3 - {1'b0, cfg.wait_hold[5:4]} || $past(wr_wait, 2))
    else $error("16-bit wait count wrong");
  chk_addr_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cmd_ends |=> (hold_q ? (isa_addr_valid && isa_cmd_n && !cyc_done)
                         : (!isa_addr_valid && cyc_done)))
    else $error("address hold after command wrong");
  chk_reset_vals: assert property (@(posedge clk_sys)
    $fell(sys_rst) |-> cfg.cmd_delay == 8'h05 && cfg.wait_hold == 8'h00)
    else $error("register reset values wrong");

endmodule // ictc_top
`default_nettype wire

// [testbench/ictc_card.sv]
// isa card side model: times the strobes it sees on the bus
`timescale 1ns/1ps
`default_nettype none
module ictc_card
(
  input wire logic clk_sys,
  input wire logic isa_ale,
  input wire logic isa_cmd_n,
  input wire logic isa_addr_valid,
  output logic [15:0] dly_clk,
  output logic [15:0] low_clk,
  output logic [15:0] hold_clk
);
  logic [15:0] cyc = 16'h0;
  logic [15:0] t_ale = 16'h0;
  logic [15:0] t_fall = 16'h0;
  logic [15:0] t_rise = 16'h0;
  logic [15:0] t_av = 16'h0;
  logic ale_q = 1'b0;
  logic cmd_q = 1'b1;
  logic av_q = 1'b0;

  // ----------------------------------------------------------------
  // edge timing
  // ----------------------------------------------------------------
  // a card has no clock of its own here; edges are stamped in clk_sys
  // cycles so every span is a whole number of system clocks
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 16'h1;
    ale_q <= isa_ale;
    cmd_q <= isa_cmd_n;
    av_q <= isa_addr_valid;
    if (ale_q && !isa_ale)
      t_ale <= cyc;
    if (cmd_q && !isa_cmd_n)
      t_fall <= cyc;
    if (!cmd_q && isa_cmd_n)
      t_rise <= cyc;
    if (av_q && !isa_addr_valid)
      t_av <= cyc;
  end

  assign dly_clk = t_fall - t_ale;
  assign low_clk = t_rise - t_fall;
  assign hold_clk = t_av - t_rise;
endmodule // ictc_card
`default_nettype wire

// [testbench/tb_top.sv]
// self-checking bench for the isa cycle timing block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ictc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cyc_req = 1'b0;
  ictc_type_t cyc_type = ICTC_IO;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cyc_busy, cyc_done, isa_ale, isa_cmd_n;
  logic isa_addr_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] dly_clk, low_clk, hold_clk;
  int error_cnt = 0;
  int check_count = 0;

  always #2.5 clk_sys = ~clk_sys;

  ictc_top i_dut (.clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cyc_req, .cyc_type,
    .cyc_busy, .cyc_done, .isa_ale, .isa_cmd_n, .isa_addr_valid);

  ictc_card u_card (.clk_sys, .isa_ale, .isa_cmd_n, .isa_addr_valid,
    .dly_clk, .low_clk, .hold_clk);

  // ----------------------------------------------------------------
  // checking and reporting
  // ----------------------------------------------------------------
  task automatic test_done;
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // one clk_sys of slack: the bus clock tick phase is free-running
  task automatic chk_near(input logic [15:0] got, input int exp);
    int g;
    g = got;
    check_count++;
    if ($isunknown(got) || g > exp + 1 || g < exp - 1)
    begin
      error_cnt++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tmo;
    chk(32'h0, 32'h1);
    test_done();
  endtask

  // ----------------------------------------------------------------
  // bus master and cycle driver
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, input logic [1:0] er);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 50);
    if (s_axi_bvalid !== 1'b1)
      tmo();
    chk(32'(s_axi_bresp), 32'(er));
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
    input logic [1:0] er);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 50);
    if (s_axi_rvalid !== 1'b1)
      tmo();
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask

  // spans in clk_sys cycles: one bus clock is 25 of them
  task automatic run_cyc(input ictc_type_t t, input int dly,
    input int low, input int hold);
    int n;
    cyc_type <= t;
    cyc_req <= 1'b1;
    @(posedge clk_sys);
    cyc_req <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
      if (n == 1)
        chk(32'(cyc_busy), 32'h1);
    end
    while (cyc_done !== 1'b1 && n < 2000);
    if (cyc_done !== 1'b1)
      tmo();
    chk(32'(cyc_busy), 32'h0);
    @(posedge clk_sys);
    chk(32'(cyc_done), 32'h0);
    chk_near(dly_clk, dly);
    chk_near(low_clk, low);
    chk_near(hold_clk, hold);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(32'(isa_cmd_n), 32'h1);
    axi_rd(8'h14, 32'h05, RESP_OKAY);
    axi_rd(8'h40, 32'h00, RESP_OKAY);
    axi_rd(8'h08, 32'h00, RESP_SLVERR);
  endtask

  task automatic t_defaults;
    run_cyc(ICTC_IO, 25, 150, 0);
    run_cyc(ICTC_MEM8, 25, 150, 0);
    run_cyc(ICTC_MEM16, 0, 100, 0);
  endtask

  // every code of every field; reserved bits written as zero
  task automatic t_codes;
    int c;
    int h;
    logic [1:0] k;
    logic [7:0] cd;
    logic [7:0] wh;
    for (c = 0; c < 4; c++)
    begin
      k = 2'(c);
      h = 25 * (c % 2);
      cd = {2'b00, k, ~k, k};
      wh = {k[0], 1'b0, ~k, k, 2'b00};
      axi_wr(ADDR_CMD_DELAY, 32'(cd), 4'h1, RESP_OKAY);
      axi_wr(ADDR_WAIT_HOLD, 32'(wh), 4'h1, RESP_OKAY);
      axi_rd(ADDR_WAIT_HOLD, 32'(wh), RESP_OKAY);
      run_cyc(ICTC_IO, 25 * c, 25 * (6 - c), h);
      run_cyc(ICTC_MEM8, 25 * (3 - c), 25 * (6 - c), h);
      run_cyc(ICTC_MEM16, 25 * c, 25 * (c + 1), h);
    end
  endtask

  task automatic t_bus;
    axi_wr(8'h08, 32'hFF, 4'h1, RESP_SLVERR);
    axi_wr(ADDR_CMD_DELAY, 32'h3F, 4'h0, RESP_OKAY);
    axi_rd(ADDR_CMD_DELAY, 32'h33, RESP_OKAY);
    axi_wr(ADDR_WAIT_HOLD, 32'hAB00_0024, 4'h1, RESP_OKAY);
    axi_rd(ADDR_WAIT_HOLD, 32'h24, RESP_OKAY);
    run_cyc(ICTC_MEM16, 75, 50, 0);
    run_cyc(ICTC_IO, 75, 125, 0);
  endtask

  initial
  begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_defaults();
    t_codes();
    t_bus();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
